// *** shared/ltc_params.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the line
 * termination control registers.
 * Assumes inclusion by bare name, ahead of the package and the modules.
 */
`ifndef LTC_PARAMS_SVH
`define LTC_PARAMS_SVH

// ============================================================
// Register offsets
`define LTC_AC_TERM_OFFSET 8'h1e
`define LTC_CTRL5_OFFSET 8'h1f

// ============================================================
// Reset values and writable masks
`define LTC_AC_TERM_RESET 8'h00
`define LTC_CTRL5_RESET 8'h20
`define LTC_AC_TERM_MASK 8'h3f

// ============================================================
// Field positions
`define LTC_AC_DOUBLE_BIT 4
`define LTC_AC_IMP_HI 3
`define LTC_AC_IMP_LO 0
`define LTC_C5_FULL_BIT 7
`define LTC_C5_FOH_HI 6
`define LTC_C5_FOH_LO 5
`define LTC_C5_SPEED2_BIT 3
`define LTC_C5_RX_HIGHPASS_SELECT_BIT 1
`define LTC_C5_LINE_VOLT_ZERO_FORCE_OFF_BIT 0

// ============================================================
// Timing: one millisecond at the 25 MHz reference clock
`define LTC_CLK_HZ 25000000
`define LTC_MS_PER_S 1000
`define LTC_MS_CYCLES (`LTC_CLK_HZ / `LTC_MS_PER_S)

// Off-hook counter lengths in milliseconds
`define LTC_FOH_MS_00 10'd512
`define LTC_FOH_MS_01 10'd128
`define LTC_FOH_MS_10 10'd64
`define LTC_FOH_MS_11 10'd8

// Line voltage forcing threshold in volts, one volt per count
`define LTC_LV_FORCE_MAX 8'h03

// DC pin voltage in millivolts for each adjust code
`define LTC_DCV_MV_00 12'd3100
`define LTC_DCV_MV_01 12'd3200
`define LTC_DCV_MV_10 12'd3350
`define LTC_DCV_MV_11 12'd3500

`endif

// *** shared/ltc_pkg.sv ***
/*
 * Types shared by the line termination control modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ltc_pkg;
    // Hang-up release class selected by speed bits and spark quench.
    typedef enum logic [1:0] {
        LTC_HANG_FAST = 2'h0,
        LTC_HANG_3MS = 2'h1,
        LTC_HANG_26MS = 2'h2
    } ltc_hang_e;

    // Transmit/receive full-scale level selection.
    typedef enum logic [1:0] {
        LTC_FS_DEFAULT = 2'h0,
        LTC_FS_3P2DBM = 2'h1,
        LTC_FS_6DBM = 2'h2
    } ltc_fs_e;

    // Off-hook counter states, one-hot.
    typedef enum logic [2:0] {
        LTC_OH_IDLE = 3'h1,
        LTC_OH_COUNT = 3'h2,
        LTC_OH_DONE = 3'h4
    } ltc_oh_e;
endpackage : ltc_pkg

`default_nettype wire

// *** shared/ltc_if.sv ***
/*
 * Carrier between the register core and the line voltage reader.
 * Assumes both ends share one clock.
 */
`default_nettype none

interface ltc_if;
    logic force_off;
    logic [7:0] reading;
    modport core (output force_off, input reading);
    modport volt (input force_off, output reading);
endinterface : ltc_if

`default_nettype wire

// *** verilog/ltc_line_volt.sv ***
/*
 * Line voltage reader: synchronises the raw line-side reading and forces
 * it to zero at low voltage unless forcing is switched off.
 * Assumes the raw reading comes from another domain and is held steady
 * for several reference clocks between changes.
 */
`default_nettype none
`include "ltc_params.svh"

module ltc_line_volt (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] raw_in,
    ltc_if.volt lv
);
    import ltc_pkg::*;

    logic [7:0] s1_r, s2_r, s3_r, stable_r, mag;
    logic low;

    // ============================================================
    // Synchroniser
    // Three stages; a new value counts once stages two and three agree.
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
            stable_r <= 8'h00;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                stable_r <= s3_r;
            end
        end
    end

    // Magnitude of the two's complement reading, top bit is polarity.
    // signed volt count
    assign mag = stable_r[7] ? 8'(-stable_r) : stable_r;
    assign low = (mag <= `LTC_LV_FORCE_MAX);

    // Reported value, zero at three volts or less while forcing is on.
    // low voltage forcing
    always_ff @(posedge clk) begin
        if (rst) begin
            lv.reading <= 8'h00;
        end else if (!lv.force_off && low) begin
            lv.reading <= 8'h00;
        end else begin
            lv.reading <= stable_r;
        end
    end

    // ============================================================
    // Assertions
    property p_force_zero;
        @(posedge clk) disable iff (rst)
        (!lv.force_off && low) |=> (lv.reading == 8'h00);
    endproperty
    a_force_zero: assert property (p_force_zero)
        else $error("Low line voltage not forced to zero.");

    property p_zero_volt;
        @(posedge clk) disable iff (rst)
        (stable_r == 8'h00) |=> (lv.reading == 8'h00);
    endproperty
    a_zero_volt: assert property (p_zero_volt)
        else $error("Zero line voltage not reported as zero.");

    property p_pass_high;
        @(posedge clk) disable iff (rst)
        (!low || lv.force_off) |=> (lv.reading == $past(stable_r));
    endproperty
    a_pass_high: assert property (p_pass_high)
        else $error("Line voltage reading not passed through.");

    c_forced: cover property (@(posedge clk) disable iff (rst)
        !lv.force_off && low && stable_r != 8'h00);
endmodule : ltc_line_volt

`default_nettype wire

// *** verilog/ltc_regs.sv ***
/*
 * Line termination control register pair with its decoded controls:
 * impedance, full-scale level, off-hook counter, hang-up class, receive
 * high-pass corner and the line voltage reading.
 * Assumes a single-cycle register port on the reference clock and that
 * seize and speed inputs come from logic on the same clock.
 */
`default_nettype none
`include "ltc_params.svh"

module ltc_regs #(
    parameter int MS_CYCLES = `LTC_MS_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic LINE_SEIZE,
    input wire logic HANGUP_SPEED_PRIMARY,
    input wire logic [1:0] SPARK_QUENCH_SELECT,
    input wire logic [1:0] DC_PIN_VOLT_ADJUST,
    input wire logic [7:0] LINE_VOLT_RAW,
    output logic [3:0] LINE_IMPEDANCE_SELECT,
    output ltc_pkg::ltc_fs_e FULL_SCALE_LEVEL,
    output logic RX_HIGHPASS_SELECT,
    output logic OFFHOOK_DONE,
    output ltc_pkg::ltc_hang_e HANGUP_CLASS,
    output logic [11:0] DC_PIN_MILLIVOLT,
    output logic [7:0] LINE_VOLT_READING
);
    import ltc_pkg::*;

    logic [7:0] ac_r, c5_r;
    logic wr_ac, wr_c5;
    logic [15:0] div_r;
    logic tick_r;
    logic [9:0] ms_r;
    ltc_oh_e oh_r, oh_nxt;
    ltc_if lvif ();

    // Off-hook counter length in milliseconds for a two-bit code.
    function automatic logic [9:0] foh_ms(input logic [1:0] code);
        unique case (code)
            2'h0: foh_ms = `LTC_FOH_MS_00;
            2'h1: foh_ms = `LTC_FOH_MS_01;
            2'h2: foh_ms = `LTC_FOH_MS_10;
            2'h3: foh_ms = `LTC_FOH_MS_11;
        endcase
    endfunction

    // Hang-up class from primary speed, extra speed and spark quench.
    function automatic ltc_hang_e hang_of(input logic p, input logic x,
                                          input logic [1:0] sq);
        if (p && sq == 2'h3) begin
            hang_of = LTC_HANG_26MS;
        end else if (!p && x && sq == 2'h0) begin
            hang_of = LTC_HANG_3MS;
        end else begin
            hang_of = LTC_HANG_FAST;
        end
    endfunction

    // ============================================================
    // Register port
    // Write strobes decoded from the printed offsets.
    assign wr_ac = REG_WR && (REG_ADDR == `LTC_AC_TERM_OFFSET);
    assign wr_c5 = REG_WR && (REG_ADDR == `LTC_CTRL5_OFFSET);

    // AC termination register; top two bits are never stored.
    // upper bits dropped
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ac_r <= `LTC_AC_TERM_RESET;
        end else if (wr_ac) begin
            ac_r <= REG_WDATA & `LTC_AC_TERM_MASK;
        end
    end

    // Control-5 register, stored whole so reserved bits read back.
    // full byte kept
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            c5_r <= `LTC_CTRL5_RESET;
        end else if (wr_c5) begin
            c5_r <= REG_WDATA;
        end
    end

    // Read data, registered; unmapped offsets read zero.
    // read back path
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `LTC_AC_TERM_OFFSET: REG_RDATA <= ac_r;
                `LTC_CTRL5_OFFSET: REG_RDATA <= c5_r;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // ============================================================
    // Decoded controls
    // Bit 5 of the AC register is read by nothing here.
    // impedance code
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LINE_IMPEDANCE_SELECT <= 4'h0;
        end else begin
            LINE_IMPEDANCE_SELECT <= ac_r[`LTC_AC_IMP_HI:`LTC_AC_IMP_LO];
        end
    end

    // Full-scale level; the doubled level takes precedence.
    // doubled level
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            FULL_SCALE_LEVEL <= LTC_FS_DEFAULT;
        end else if (ac_r[`LTC_AC_DOUBLE_BIT]) begin
            FULL_SCALE_LEVEL <= LTC_FS_6DBM;
        end else if (c5_r[`LTC_C5_FULL_BIT]) begin
            FULL_SCALE_LEVEL <= LTC_FS_3P2DBM;
        end else begin
            FULL_SCALE_LEVEL <= LTC_FS_DEFAULT;
        end
    end

    // Receive corner, hang-up class and DC pin voltage.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RX_HIGHPASS_SELECT <= 1'b0;
            HANGUP_CLASS <= LTC_HANG_FAST;
            DC_PIN_MILLIVOLT <= `LTC_DCV_MV_00;
        end else begin
            RX_HIGHPASS_SELECT <= c5_r[`LTC_C5_RX_HIGHPASS_SELECT_BIT];
            HANGUP_CLASS <= hang_of(HANGUP_SPEED_PRIMARY,
                c5_r[`LTC_C5_SPEED2_BIT], SPARK_QUENCH_SELECT);
            unique case (DC_PIN_VOLT_ADJUST)
                2'h0: DC_PIN_MILLIVOLT <= `LTC_DCV_MV_00;
                2'h1: DC_PIN_MILLIVOLT <= `LTC_DCV_MV_01;
                2'h2: DC_PIN_MILLIVOLT <= `LTC_DCV_MV_10;
                2'h3: DC_PIN_MILLIVOLT <= `LTC_DCV_MV_11;
            endcase
        end
    end

    // ============================================================
    // Off-hook counter
    // Millisecond enable from a divider of the reference clock.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            div_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (div_r == 16'(MS_CYCLES - 1)) begin
            div_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // Counter state: counts while seized, done at the selected length.
    always_comb begin
        oh_nxt = oh_r;
        unique case (oh_r)
            LTC_OH_IDLE: if (LINE_SEIZE) oh_nxt = LTC_OH_COUNT;
            LTC_OH_COUNT: begin
                if (!LINE_SEIZE) begin
                    oh_nxt = LTC_OH_IDLE;
                end else if (ms_r >= foh_ms(c5_r[6:5])) begin
                    oh_nxt = LTC_OH_DONE;
                end
            end
            LTC_OH_DONE: if (!LINE_SEIZE) oh_nxt = LTC_OH_IDLE;
            default: oh_nxt = LTC_OH_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            oh_r <= LTC_OH_IDLE;
            ms_r <= 10'h000;
            OFFHOOK_DONE <= 1'b0;
        end else begin
            oh_r <= oh_nxt;
            OFFHOOK_DONE <= (oh_nxt == LTC_OH_DONE);
            if (oh_r != LTC_OH_COUNT) begin
                ms_r <= 10'h000;
            end else if (tick_r) begin
                ms_r <= ms_r + 10'h001;
            end
        end
    end

    // ============================================================
    // Line voltage reading
    // forcing control
    assign lvif.force_off = c5_r[`LTC_C5_LINE_VOLT_ZERO_FORCE_OFF_BIT];

    ltc_line_volt u_volt (
        .clk(REF_CLK),
        .rst(RST),
        .raw_in(LINE_VOLT_RAW),
        .lv(lvif.volt)
    );

    assign LINE_VOLT_READING = lvif.reading;

    // ============================================================
    // Assertions
    property p_hi_zero;
        @(posedge REF_CLK) disable iff (RST)
        wr_ac ##1 (REG_RD && REG_ADDR == `LTC_AC_TERM_OFFSET)
            |=> (REG_RDATA[7:6] == 2'h0);
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("AC register upper bits not zero.");

    property p_readback;
        logic [7:0] d;
        @(posedge REF_CLK) disable iff (RST)
        (wr_c5, d = REG_WDATA) ##1 (REG_RD && REG_ADDR == `LTC_CTRL5_OFFSET
            && !REG_WR) |=> (REG_RDATA == d);
    endproperty
    a_readback: assert property (p_readback)
        else $error("Control-5 does not read back.");

    property p_bit5_inert;
        @(posedge REF_CLK) disable iff (RST)
        (wr_ac && REG_WDATA[4:0] == ac_r[4:0])
            |=> ##1 ($stable(LINE_IMPEDANCE_SELECT)
            && $stable(FULL_SCALE_LEVEL));
    endproperty
    a_bit5_inert: assert property (p_bit5_inert)
        else $error("Reserved bit 5 changed behaviour.");

    property p_double;
        @(posedge REF_CLK) disable iff (RST)
        (wr_ac && REG_WDATA[4]) |=> ##1 (FULL_SCALE_LEVEL == LTC_FS_6DBM);
    endproperty
    a_double: assert property (p_double)
        else $error("Doubled level not selected.");

    property p_imp;
        logic [3:0] d;
        @(posedge REF_CLK) disable iff (RST)
        (wr_ac, d = REG_WDATA[3:0]) ##1 !wr_ac
            |=> (LINE_IMPEDANCE_SELECT == d);
    endproperty
    a_imp: assert property (p_imp)
        else $error("Impedance select does not follow write.");

    property p_full;
        @(posedge REF_CLK) disable iff (RST)
        (!ac_r[4] && c5_r[7]) |=> (FULL_SCALE_LEVEL == LTC_FS_3P2DBM);
    endproperty
    a_full: assert property (p_full)
        else $error("3.2 dBm level not selected.");

    property p_len;
        @(posedge REF_CLK) disable iff (RST)
        $rose(OFFHOOK_DONE) |-> ($past(ms_r) == foh_ms($past(c5_r[6:5])));
    endproperty
    a_len: assert property (p_len)
        else $error("Off-hook counter length wrong.");

    property p_hang;
        @(posedge REF_CLK) disable iff (RST)
        (HANGUP_SPEED_PRIMARY && SPARK_QUENCH_SELECT == 2'h3)
            |=> (HANGUP_CLASS == LTC_HANG_26MS);
    endproperty
    a_hang: assert property (p_hang)
        else $error("Spark quench hang-up not selected.");

    property p_rx_highpass_select;
        @(posedge REF_CLK) disable iff (RST)
        wr_c5 |=> ##1 (RX_HIGHPASS_SELECT == $past(REG_WDATA[1], 2));
    endproperty
    a_rx_highpass_select: assert property (p_rx_highpass_select)
        else $error("High-pass select does not follow write.");

    c_done: cover property (@(posedge REF_CLK) disable iff (RST)
        $rose(OFFHOOK_DONE));
    c_double: cover property (@(posedge REF_CLK) disable iff (RST)
        FULL_SCALE_LEVEL == LTC_FS_6DBM);
    c_3ms: cover property (@(posedge REF_CLK) disable iff (RST)
        HANGUP_CLASS == LTC_HANG_3MS);
endmodule : ltc_regs

`default_nettype wire

// *** tb/line_termination_control_regs_tb.sv ***
/*
 * Self-checking bench for the line termination control register pair.
 * Assumes the shared header, package and interface and the design modules
 * are compiled ahead of it; the bench drives every design input itself.
 */
`default_nettype none
`include "ltc_params.svh"

module line_termination_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ltc_pkg::*;

    // ============================================================
    // Signals and model state
    localparam int MS = 4;
    localparam int LIMIT = 20000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic line_seize = 1'b0;
    logic hangup_speed_primary = 1'b0;
    logic [1:0] spark_quench_select = 2'h0;
    logic [1:0] dc_pin_volt_adjust = 2'h0;
    logic [7:0] line_volt_raw = 8'h00;
    logic [3:0] line_impedance_select;
    ltc_fs_e full_scale_level;
    logic rx_highpass_select;
    logic offhook_done;
    ltc_hang_e hangup_class;
    logic [11:0] dc_pin_millivolt;
    logic [7:0] line_volt_reading;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int ac_m = 0;
    int c5_m = 32'h20;
    logic [15:0] lfsr = 16'h9e8a;
    int mv[4] = '{3100, 3200, 3350, 3500};
    int offhook_counter_length[4] = '{512, 128, 64, 8};
    logic [7:0] lv[11] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'hfd, 8'hfc,
        8'h7f, 8'h80, 8'h00, 8'h05, 8'hfb};

    ltc_regs #(.MS_CYCLES(MS)) dut_u (
        .REF_CLK(ref_clk),
        .RST(rst),
        .REG_ADDR(reg_addr),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata),
        .LINE_SEIZE(line_seize),
        .HANGUP_SPEED_PRIMARY(hangup_speed_primary),
        .SPARK_QUENCH_SELECT(spark_quench_select),
        .DC_PIN_VOLT_ADJUST(dc_pin_volt_adjust),
        .LINE_VOLT_RAW(line_volt_raw),
        .LINE_IMPEDANCE_SELECT(line_impedance_select),
        .FULL_SCALE_LEVEL(full_scale_level),
        .RX_HIGHPASS_SELECT(rx_highpass_select),
        .OFFHOOK_DONE(offhook_done),
        .HANGUP_CLASS(hangup_class),
        .DC_PIN_MILLIVOLT(dc_pin_millivolt),
        .LINE_VOLT_READING(line_volt_reading)
    );

    // ============================================================
    // Helpers
    // Next value of the stimulus shift register.
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Compares a design value with the model, four-state exact.
    task automatic chk_v(input logic [11:0] got, input logic [11:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Compares a measured delay in cycles with its allowed window.
    task automatic chk_time(input int got, input int lo, input int hi,
                            input string what);
        tests_run++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[FAIL] %0t %s took %0d cycles", $time, what, got);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One-cycle write strobe; the model only keeps mapped offsets.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a == `LTC_AC_TERM_OFFSET) ac_m = d & 8'h3f;
        if (a == `LTC_CTRL5_OFFSET) c5_m = d;
    endtask

    // One-cycle read strobe; data is taken once the answer edge settles.
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Write, then read the same offset in the very next cycle.
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] w,
                         output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        if (a == `LTC_AC_TERM_OFFSET) ac_m = w & 8'h3f;
        if (a == `LTC_CTRL5_OFFSET) c5_m = w;
    endtask

    // Reads both registers back and checks the impedance, full-scale level and high-pass outputs.
    task automatic check_all();
        logic [7:0] d;
        int fs;
        reg_read(`LTC_AC_TERM_OFFSET, d);
        chk_v({4'h0, d}, 12'(ac_m), "ac readback");
        reg_read(`LTC_CTRL5_OFFSET, d);
        chk_v({4'h0, d}, 12'(c5_m), "c5 readback");
        fs = ac_m[4] ? 2 : (c5_m[7] ? 1 : 0);
        chk_v({8'h0, line_impedance_select}, 12'(ac_m & 15), "imp");
        chk_v({10'h0, full_scale_level}, 12'(fs), "level");
        chk_v({11'h0, rx_highpass_select}, 12'(c5_m[1]), "hp");
    endtask

    // ============================================================
    // Clock and cycle ceiling
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // A run that outlives the ceiling counts as a mismatch.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            wrap_up();
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] a;
        int n;
        int h;
        int sv;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        check_all();
        chk_v(dc_pin_millivolt, 12'd3100, "dcv reset");
        // Every impedance code, with bit 5 toggled and the dead bits set.
        for (int i = 0; i < 16; i++) begin
            reg_write(`LTC_AC_TERM_OFFSET, {2'b11, i[0], 1'b0, i[3:0]});
            check_all();
        end
        // Same low bits with bit 5 flipped: no decoded output may move.
        reg_write(`LTC_AC_TERM_OFFSET, 8'h0f);
        check_all();
        // full line side, no basic limits
        @(posedge ref_clk);
        dc_pin_volt_adjust <= 2'h3;
        // Random writes, each read back in the next cycle, with unmapped
        // traffic in between.
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            wr_rd(`LTC_AC_TERM_OFFSET, lfsr[7:0], d);
            chk_v({4'h0, d}, 12'(ac_m), "ac wr-rd");
            lfsr = lfsr_next(lfsr);
            wr_rd(`LTC_CTRL5_OFFSET, lfsr[7:0] & 8'heb, d);
            chk_v({4'h0, d}, 12'(c5_m), "c5 wr-rd");
            a = lfsr[8] ? 8'h1d : 8'h20;
            reg_write(a, lfsr[15:8]);
            reg_read(a, d);
            chk_v({4'h0, d}, 12'h000, "unmapped");
            check_all();
        end
        reg_write(`LTC_AC_TERM_OFFSET, 8'h00);
        reg_write(`LTC_CTRL5_OFFSET, `LTC_CTRL5_RESET);
        check_all();
        // DC pin voltage for each adjust code.
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            dc_pin_volt_adjust <= 2'(i);
            repeat (3) @(posedge ref_clk);
            #1;
            chk_v(dc_pin_millivolt, 12'(mv[i]), "dcv");
        end
        // Hang-up class over all speed and spark quench combinations.
        for (int i = 0; i < 16; i++) begin
            reg_write(`LTC_CTRL5_OFFSET, {4'h0, i[1], 3'h0});
            @(posedge ref_clk);
            hangup_speed_primary <= i[0];
            spark_quench_select <= i[3:2];
            repeat (3) @(posedge ref_clk);
            #1;
            h = 0;
            if (!i[0] && i[3:2] == 2'h0) h = i[1];
            if (i[0] && i[3:2] == 2'h3) h = 2;
            chk_v({10'h0, hangup_class}, 12'(h), "hangup");
        end
        // Off-hook counter per code, after an aborted first seize.
        for (int i = 0; i < 4; i++) begin
            reg_write(`LTC_CTRL5_OFFSET, {1'b0, 2'(i), 5'h0});
            line_seize <= 1'b1;
            repeat (10) @(posedge ref_clk);
            line_seize <= 1'b0;
            repeat (2) @(posedge ref_clk);
            line_seize <= 1'b1;
            n = 0;
            while (offhook_done !== 1'b1 && n < (offhook_counter_length[i] + 3) * MS) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            chk_time(n, (offhook_counter_length[i] - 1) * MS, (offhook_counter_length[i] + 2) * MS, "oh");
            @(posedge ref_clk);
            line_seize <= 1'b0;
            repeat (3) @(posedge ref_clk);
            #1;
            chk_v({11'h0, offhook_done}, 12'h000, "oh drop");
        end
        // Line voltage forcing on, then off for the last three values.
        for (int i = 0; i < 11; i++) begin
            reg_write(`LTC_CTRL5_OFFSET, {7'h0, i >= 8});
            line_volt_raw <= lv[i];
            repeat (8) @(posedge ref_clk);
            #1;
            sv = $signed(lv[i]);
            d = (i < 8 && sv >= -3 && sv <= 3) ? 8'h00 : lv[i];
            chk_v({4'h0, line_volt_reading}, {4'h0, d}, "lv");
        end
        wrap_up();
    end
endmodule // line_termination_control_regs_tb

`default_nettype wire
